// >>> hw/mie_data_mem.sv
/*
  Data memory of the core: one write port and two asynchronous read ports.
  Assumes the parent supplies at most one write per clock; contents are not reset.
*/
`timescale 1ns/100ps
`default_nettype none
module mie_data_mem (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [mie_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [mie_pkg::DATA_W-1:0] wr_data,
  // Operand read port
  input wire logic [mie_pkg::ADDR_W-1:0] rd_addr,
  output logic [mie_pkg::DATA_W-1:0] rd_data,
  // Observation read port
  input wire logic [mie_pkg::ADDR_W-1:0] peek_addr,
  output logic [mie_pkg::DATA_W-1:0] peek_data
);
  import mie_pkg::*;

  // Full 256-byte space kept so any address decodes; low bytes act as plain storage here
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
  assign peek_data = mem[peek_addr];

endmodule
`default_nettype wire

// >>> hw/mie_execute.sv
/*
  Execute stage of the 8-bit core for moves, OR, returns, rotates, subtract with borrow
  and decrement-skip-if-zero, with the program counter, accumulator, flags and return stack.
  Assumes instructions arrive already decoded and synchronous to clk; the caller holds a
  request until it sees ready high in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE1: Jump loads the program counter with the target; flags stay.
// RULE2: Memory-to-accumulator move copies the byte; flags stay.
// RULE3: Immediate move loads the 8-bit constant into the accumulator; flags stay.
// RULE4: Accumulator store writes the accumulator to memory; flags stay.
// RULE5: No-operation only advances the program counter by one.
// RULE6: OR with memory or immediate into accumulator; only zero flag updates.
// RULE7: OR into memory writes the result back; only zero flag updates.
// RULE8: Subroutine return pops the program counter, takes two cycles, no flags.
// RULE9: Return-with-value pops the program counter and loads the immediate.
// RULE10: Interrupt return pops the program counter and sets global interrupt enable.
// RULE11: Rotate left writes memory with bit 7 into bit 0; no flags.
// RULE12: Rotate left to accumulator; memory and flags unchanged.
// RULE13: Rotate left through carry into memory; only carry changes.
// RULE14: Rotate left through carry to accumulator; carry from bit 7; memory kept.
// RULE15: Rotate right writes memory with bit 0 into bit 7; no flags.
// RULE16: Rotate right to accumulator; memory and flags unchanged.
// RULE17: Rotate right through carry into memory; only carry changes.
// RULE18: Rotate right through carry to accumulator; carry from bit 0; memory kept.
// RULE19: Subtract memory and inverted carry from accumulator; four flags update.
// RULE20: Same subtraction written to memory; four flags update.
// RULE21: Decrement memory; zero result skips next instruction, two cycles, else one.
// RULE22: Flags an instruction does not list keep their previous values.
module mie_execute (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Decoded instruction request
  input wire logic instr_valid,
  input wire mie_pkg::mie_op_t instr_op,
  input wire logic [mie_pkg::ADDR_W-1:0] instr_addr,
  input wire logic [mie_pkg::DATA_W-1:0] instr_imm,
  input wire logic [mie_pkg::PC_W-1:0] instr_target,
  output logic instr_ready,
  output logic instr_done,
  output logic skip_taken,
  // Stack entry from call and interrupt logic
  input wire logic push_valid,
  input wire logic [mie_pkg::PC_W-1:0] push_addr,
  input wire logic gie_clear,
  input wire logic stack_error_clear,
  // Core state
  output logic [mie_pkg::PC_W-1:0] pc,
  output logic [mie_pkg::DATA_W-1:0] accumulator,
  output logic overflow_flag,
  output logic zero_flag,
  output logic aux_carry_flag,
  output logic carry_flag,
  output logic global_interrupt_enable,
  output logic [2:0] stack_depth,
  output logic stack_overflow,
  output logic stack_underflow,
  // Memory observation
  input wire logic [mie_pkg::ADDR_W-1:0] peek_addr,
  output logic [mie_pkg::DATA_W-1:0] peek_data
);
  import mie_pkg::*;

  mie_state_t cur;
  mie_state_t next_cur;

  logic take;
  logic do_push;
  logic mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] mem_peek;
  logic [DATA_W-1:0] sub_result;
  logic sub_carry;
  logic sub_aux;
  logic sub_ovf;
  logic sub_zero;
  logic [DATA_W-1:0] dec_value;
  logic [DATA_W-1:0] or_value;
  logic [DATA_W:0] rot_c;

  // Rotates shared by the memory and accumulator forms
  function automatic logic [DATA_W-1:0] rot_left(input logic [DATA_W-1:0] b);
    rot_left = {b[6:0], b[7]};
  endfunction

  function automatic logic [DATA_W-1:0] rot_right(input logic [DATA_W-1:0] b);
    rot_right = {b[0], b[7:1]};
  endfunction

  // Nine-bit loop: top bit of the answer is the new carry
  function automatic logic [DATA_W:0] rot_left_carry(input logic [DATA_W-1:0] b, input logic c);
    rot_left_carry = {b[7], b[6:0], c};
  endfunction

  function automatic logic [DATA_W:0] rot_right_carry(input logic [DATA_W-1:0] b, input logic c);
    rot_right_carry = {b[0], c, b[7:1]};
  endfunction

  function automatic logic is_zero(input logic [DATA_W-1:0] b);
    is_zero = (b == 8'h00);
  endfunction

  // Asynchronous reads give the operand in the taking cycle
  mie_data_mem u_mem (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(instr_addr),
    .wr_data(mem_wdata),
    .rd_addr(instr_addr),
    .rd_data(mem_rdata),
    .peek_addr(peek_addr),
    .peek_data(mem_peek)
  );

  // One adder for both subtract forms keeps their flags alike
  mie_sub_borrow u_sub (
    .a(cur.accumulator),
    .m(mem_rdata),
    .carry_in(cur.carry_flag),
    .result(sub_result),
    .carry_out(sub_carry),
    .aux_carry_out(sub_aux),
    .overflow_out(sub_ovf),
    .zero_out(sub_zero)
  );

  // Shared results, selected only by the operations that own them
  assign dec_value = mem_rdata - 8'h01;
  assign or_value = cur.accumulator | mem_rdata;

  // A push takes the cycle so stack pointer and memory never see two owners at once
  assign do_push = cur.ready && push_valid;
  assign take = cur.ready && instr_valid && !push_valid;

  always_comb begin
    next_cur = cur;
    mem_we = 1'b0;
    mem_wdata = cur.accumulator;
    rot_c = 9'h000;
    next_cur.done = 1'b0;
    next_cur.skip_taken = 1'b0;
    next_cur.peek_data = mem_peek;

    // Dummy cycle of a two-cycle instruction runs down here
    if (cur.wait_count != 2'h0) begin
      next_cur.wait_count = cur.wait_count - 2'h1;
    end

    // Clears come first so a set in the same cycle wins
    if (gie_clear) begin
      next_cur.global_interrupt_enable = 1'b0;
    end
    if (stack_error_clear) begin
      next_cur.stack_overflow = 1'b0;
      next_cur.stack_underflow = 1'b0;
    end

    // Full stack overwrites its oldest entry, as a circular stack does
    if (do_push) begin
      next_cur.stack_ptr = cur.stack_ptr + 2'h1;
      next_cur.stack[cur.stack_ptr + 2'h1] = push_addr;
      if (cur.stack_depth == 3'h4) begin
        next_cur.stack_overflow = 1'b1;
      end else begin
        next_cur.stack_depth = cur.stack_depth + 3'h1;
      end
    end

    // Operations act at the taking edge
    if (take) begin
      next_cur.done = 1'b1;
      next_cur.pc = cur.pc + PC_STEP;
      next_cur.wait_count = NORMAL_CYCLES - 2'h1;
      // Flags are copied from cur above and only touched where an operation owns them (see RULE22)
      case (instr_op)
        OP_NOP: begin
          next_cur.pc = cur.pc + PC_STEP; // see RULE5
        end
        OP_JUMP: begin
          next_cur.pc = instr_target; // see RULE1
        end
        OP_LOAD_MEM: begin
          next_cur.accumulator = mem_rdata; // see RULE2
        end
        OP_LOAD_IMM: begin
          next_cur.accumulator = instr_imm; // see RULE3
        end
        OP_STORE_ACC: begin
          mem_we = 1'b1; // see RULE4
          mem_wdata = cur.accumulator;
        end
        OP_OR_MEM: begin
          next_cur.accumulator = or_value; // see RULE6
          next_cur.zero_flag = is_zero(or_value);
        end
        OP_OR_IMM: begin
          next_cur.accumulator = cur.accumulator | instr_imm; // see RULE6
          next_cur.zero_flag = is_zero(cur.accumulator | instr_imm);
        end
        OP_OR_TO_MEMORY: begin
          mem_we = 1'b1; // see RULE7
          mem_wdata = or_value;
          next_cur.zero_flag = is_zero(or_value);
        end
        OP_RETURN, OP_RETURN_VALUE, OP_INTERRUPT_RETURN: begin
          // Pop from an empty stack still reads the top slot but is recorded
          next_cur.pc = cur.stack[cur.stack_ptr]; // see RULE8
          next_cur.stack_ptr = cur.stack_ptr - 2'h1;
          next_cur.wait_count = RETURN_CYCLES - 2'h1; // see RULE8
          if (cur.stack_depth == 3'h0) begin
            next_cur.stack_underflow = 1'b1;
          end else begin
            next_cur.stack_depth = cur.stack_depth - 3'h1;
          end
          if (instr_op == OP_RETURN_VALUE) begin
            next_cur.accumulator = instr_imm; // see RULE9
          end
          if (instr_op == OP_INTERRUPT_RETURN) begin
            next_cur.global_interrupt_enable = 1'b1; // see RULE10
          end
        end
        OP_ROT_LEFT: begin
          mem_we = 1'b1; // see RULE11
          mem_wdata = rot_left(mem_rdata);
        end
        OP_ROT_LEFT_TO_ACC: begin
          next_cur.accumulator = rot_left(mem_rdata); // see RULE12
        end
        OP_ROT_LEFT_CARRY: begin
          rot_c = rot_left_carry(mem_rdata, cur.carry_flag); // see RULE13
          mem_we = 1'b1;
          mem_wdata = rot_c[DATA_W-1:0];
          next_cur.carry_flag = rot_c[DATA_W];
        end
        OP_ROT_LEFT_CARRY_TO_ACC: begin
          rot_c = rot_left_carry(mem_rdata, cur.carry_flag); // see RULE14
          next_cur.accumulator = rot_c[DATA_W-1:0];
          next_cur.carry_flag = rot_c[DATA_W];
        end
        OP_ROT_RIGHT: begin
          mem_we = 1'b1; // see RULE15
          mem_wdata = rot_right(mem_rdata);
        end
        OP_ROT_RIGHT_TO_ACC: begin
          next_cur.accumulator = rot_right(mem_rdata); // see RULE16
        end
        OP_ROT_RIGHT_CARRY: begin
          rot_c = rot_right_carry(mem_rdata, cur.carry_flag); // see RULE17
          mem_we = 1'b1;
          mem_wdata = rot_c[DATA_W-1:0];
          next_cur.carry_flag = rot_c[DATA_W];
        end
        OP_ROT_RIGHT_CARRY_TO_ACC: begin
          rot_c = rot_right_carry(mem_rdata, cur.carry_flag); // see RULE18
          next_cur.accumulator = rot_c[DATA_W-1:0];
          next_cur.carry_flag = rot_c[DATA_W];
        end
        // Set carry means no borrow
        OP_SUBTRACT_BORROW: begin
          next_cur.accumulator = sub_result; // see RULE19
          next_cur.overflow_flag = sub_ovf;
          next_cur.zero_flag = sub_zero;
          next_cur.aux_carry_flag = sub_aux;
          next_cur.carry_flag = sub_carry;
        end
        OP_SUBTRACT_BORROW_TO_MEM: begin
          mem_we = 1'b1; // see RULE20
          mem_wdata = sub_result;
          next_cur.overflow_flag = sub_ovf;
          next_cur.zero_flag = sub_zero;
          next_cur.aux_carry_flag = sub_aux;
          next_cur.carry_flag = sub_carry;
        end
        OP_DECREMENT_SKIP_ZERO: begin
          mem_we = 1'b1; // see RULE21
          mem_wdata = dec_value;
          // Prefetched successor is dropped by stepping past it and inserting a dummy cycle
          if (is_zero(dec_value)) begin
            next_cur.pc = cur.pc + PC_SKIP_STEP; // see RULE21
            next_cur.skip_taken = 1'b1;
            next_cur.wait_count = SKIP_CYCLES - 2'h1;
          end
        end
        default: begin
          // Codes outside this block behave as a no-operation so the program counter never stalls
          next_cur.pc = cur.pc + PC_STEP;
        end
      endcase
    end

    // Registered ready: no path from request to ready
    next_cur.ready = (next_cur.wait_count == 2'h0);
  end

  // Memory is not reset: a byte must be written before it is read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur.pc <= PC_RESET;
      cur.accumulator <= ACC_RESET;
      cur.overflow_flag <= FLAG_RESET;
      cur.zero_flag <= FLAG_RESET;
      cur.aux_carry_flag <= FLAG_RESET;
      cur.carry_flag <= FLAG_RESET;
      cur.global_interrupt_enable <= GIE_RESET;
      cur.stack <= '0;
      cur.stack_ptr <= 2'h0;
      cur.stack_depth <= 3'h0;
      cur.stack_overflow <= 1'b0;
      cur.stack_underflow <= 1'b0;
      cur.wait_count <= 2'h0;
      cur.ready <= 1'b1;
      cur.done <= 1'b0;
      cur.skip_taken <= 1'b0;
      cur.peek_data <= 8'h00;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs are bits of the registered state
  assign instr_ready = cur.ready;
  assign instr_done = cur.done;
  assign skip_taken = cur.skip_taken;
  assign pc = cur.pc;
  assign accumulator = cur.accumulator;
  assign overflow_flag = cur.overflow_flag;
  assign zero_flag = cur.zero_flag;
  assign aux_carry_flag = cur.aux_carry_flag;
  assign carry_flag = cur.carry_flag;
  assign global_interrupt_enable = cur.global_interrupt_enable;
  assign stack_depth = cur.stack_depth;
  assign stack_overflow = cur.stack_overflow;
  assign stack_underflow = cur.stack_underflow;
  assign peek_data = cur.peek_data;

endmodule
`default_nettype wire

// >>> hw/mie_sub_borrow.sv
/*
  Combinational subtract-with-borrow: a + ~m + carry, with all four arithmetic flags.
  Assumes carry_in is the current carry flag, where a set carry means no borrow.
*/
`timescale 1ns/100ps
`default_nettype none
module mie_sub_borrow (
  // Operands
  input wire logic [mie_pkg::DATA_W-1:0] a,
  input wire logic [mie_pkg::DATA_W-1:0] m,
  input wire logic carry_in,
  // Result and flags
  output logic [mie_pkg::DATA_W-1:0] result,
  output logic carry_out,
  output logic aux_carry_out,
  output logic overflow_out,
  output logic zero_out
);
  import mie_pkg::*;

  logic [DATA_W:0] full_sum;
  logic [4:0] low_sum;
  logic [DATA_W-1:0] m_inv;

  assign m_inv = ~m;
  assign full_sum = {1'b0, a} + {1'b0, m_inv} + {8'h00, carry_in};
  assign low_sum = {1'b0, a[3:0]} + {1'b0, m_inv[3:0]} + {4'h0, carry_in};
  assign result = full_sum[DATA_W-1:0];
  assign carry_out = full_sum[DATA_W];
  assign aux_carry_out = low_sum[4];
  // Signed overflow: operands of like sign giving a result of the other sign
  assign overflow_out = (a[7] == m_inv[7]) && (full_sum[7] != a[7]);
  assign zero_out = (full_sum[DATA_W-1:0] == 8'h00);

endmodule
`default_nettype wire

// >>> shared/mie_pkg.sv
/*
  Shared constants, operation codes and the register-state type of the instruction execute block.
  Assumes a single 50 MHz core clock and instructions delivered already decoded, one per request.
*/
package mie_pkg;

  // Widths of the core's datapath
  localparam int PC_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int STACK_LEVELS = 4;

  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic GIE_RESET = 1'b0;

  // Cycle counts
  localparam logic [1:0] NORMAL_CYCLES = 2'h1;
  localparam logic [1:0] RETURN_CYCLES = 2'h2;
  localparam logic [1:0] SKIP_CYCLES = 2'h2;

  // Program counter steps
  localparam logic [PC_W-1:0] PC_STEP = 12'h001;
  localparam logic [PC_W-1:0] PC_SKIP_STEP = 12'h002;

  // Decoded operations; the binary codes are this block's own
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_JUMP = 5'h01,
    OP_LOAD_MEM = 5'h02,
    OP_LOAD_IMM = 5'h03,
    OP_STORE_ACC = 5'h04,
    OP_OR_MEM = 5'h05,
    OP_OR_IMM = 5'h06,
    OP_OR_TO_MEMORY = 5'h07,
    OP_RETURN = 5'h08,
    OP_RETURN_VALUE = 5'h09,
    OP_INTERRUPT_RETURN = 5'h0a,
    OP_ROT_LEFT = 5'h0b,
    OP_ROT_LEFT_TO_ACC = 5'h0c,
    OP_ROT_LEFT_CARRY = 5'h0d,
    OP_ROT_LEFT_CARRY_TO_ACC = 5'h0e,
    OP_ROT_RIGHT = 5'h0f,
    OP_ROT_RIGHT_TO_ACC = 5'h10,
    OP_ROT_RIGHT_CARRY = 5'h11,
    OP_ROT_RIGHT_CARRY_TO_ACC = 5'h12,
    OP_SUBTRACT_BORROW = 5'h13,
    OP_SUBTRACT_BORROW_TO_MEM = 5'h14,
    OP_DECREMENT_SKIP_ZERO = 5'h15
  } mie_op_t;

  // Every flip-flop of the top module
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] accumulator;
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
    logic global_interrupt_enable;
    logic [STACK_LEVELS-1:0][PC_W-1:0] stack;
    logic [1:0] stack_ptr;
    logic [2:0] stack_depth;
    logic stack_overflow;
    logic stack_underflow;
    logic [1:0] wait_count;
    logic ready;
    logic done;
    logic skip_taken;
    logic [DATA_W-1:0] peek_data;
  } mie_state_t;

endpackage

// >>> tb/mie_exec_props.sv
/*
  Port-level checks of the execute block: request taking, program counter steps, flag holding.
  Assumes it is bound to the top module and that the bench never raises a push with a request.
*/
`timescale 1ns/100ps
`default_nettype none
module mie_exec_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Request
  input wire logic instr_valid,
  input wire mie_pkg::mie_op_t instr_op,
  input wire logic [mie_pkg::DATA_W-1:0] instr_imm,
  input wire logic [mie_pkg::PC_W-1:0] instr_target,
  input wire logic push_valid,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic skip_taken,
  // State
  input wire logic [mie_pkg::PC_W-1:0] pc,
  input wire logic [mie_pkg::DATA_W-1:0] accumulator,
  input wire logic overflow_flag,
  input wire logic zero_flag,
  input wire logic aux_carry_flag,
  input wire logic carry_flag,
  input wire logic global_interrupt_enable
);
  import mie_pkg::*;
  logic take;
  logic [3:0] flags;
  assign take = instr_valid && instr_ready && !push_valid;
  assign flags = {overflow_flag, zero_flag, aux_carry_flag, carry_flag};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_done_follows: assert property (take |=> instr_done) else $error("done missing after take");
  a_jump_target: assert property (take && instr_op == OP_JUMP |=> pc == $past(instr_target) && $stable(flags))
    else $error("jump target or flags wrong");
  a_imm_load: assert property (take && instr_op == OP_LOAD_IMM |=> accumulator == $past(instr_imm) && $stable(flags))
    else $error("immediate load wrong");
  a_nop_step: assert property (take && instr_op == OP_NOP |=> pc == 12'($past(pc) + 12'h001) && $stable(accumulator) && $stable(flags))
    else $error("no-operation changed state");
  a_or_imm_value: assert property (take && instr_op == OP_OR_IMM |=>
    accumulator == ($past(accumulator) | $past(instr_imm)) && zero_flag == (accumulator == 8'h00)) else $error("or immediate wrong");
  a_or_flags_kept: assert property (take && instr_op inside {OP_OR_MEM, OP_OR_IMM, OP_OR_TO_MEMORY} |=>
    $stable({overflow_flag, aux_carry_flag, carry_flag})) else $error("or touched other flags");
  a_return_wait: assert property (take && instr_op inside {OP_RETURN, OP_RETURN_VALUE, OP_INTERRUPT_RETURN} |=>
    !instr_ready && $stable(flags) ##1 instr_ready) else $error("return not two cycles");
  a_ret_value: assert property (take && instr_op == OP_RETURN_VALUE |=> accumulator == $past(instr_imm))
    else $error("return value not loaded");
  a_interrupt_return_enable: assert property (take && instr_op == OP_INTERRUPT_RETURN |=> global_interrupt_enable)
    else $error("interrupt enable not set");
  a_rotate_flags: assert property (take && instr_op inside {OP_ROT_LEFT, OP_ROT_LEFT_TO_ACC, OP_ROT_RIGHT,
    OP_ROT_RIGHT_TO_ACC} |=> $stable(flags)) else $error("plain rotate changed flags");
  a_sbc_zero: assert property (take && instr_op == OP_SUBTRACT_BORROW |=> zero_flag == (accumulator == 8'h00))
    else $error("subtract zero flag wrong");
  a_skip_step: assert property (skip_taken |-> pc == 12'($past(pc) + 12'h002) && !instr_ready ##1 instr_ready)
    else $error("skip step wrong");
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
  Self-checking bench of the execute block: a reference model in tasks, random and corner instructions.
  Assumes memory is written before it is read; a return issued through exec is always preceded by one push.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mie_pkg::*;
  logic clk, reset_n, instr_valid, push_valid, gie_clear, stack_error_clear;
  mie_op_t instr_op;
  logic [7:0] instr_addr, instr_imm, peek_addr, accumulator, peek_data;
  logic [11:0] instr_target, push_addr, pc;
  logic instr_ready, instr_done, skip_taken, overflow_flag, zero_flag, aux_carry_flag, carry_flag;
  logic global_interrupt_enable, stack_overflow, stack_underflow;
  logic [2:0] stack_depth;
  logic [7:0] mem [8];
  logic [7:0] acc_m;
  logic [11:0] pc_m;
  logic ov, z, ac, cy, gie, skip, two;
  logic [11:0] stk [$];
  logic [15:0] rnd;
  int error_cnt, checks_done;

  mie_execute uut (.clk, .reset_n, .instr_valid, .instr_op, .instr_addr, .instr_imm, .instr_target,
    .instr_ready, .instr_done, .skip_taken, .push_valid, .push_addr, .gie_clear, .stack_error_clear,
    .pc, .accumulator, .overflow_flag, .zero_flag, .aux_carry_flag, .carry_flag, .global_interrupt_enable,
    .stack_depth, .stack_overflow, .stack_underflow, .peek_addr, .peek_data);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [15:0] rand16();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction

  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic model(input mie_op_t op, input logic [2:0] a, input logic [7:0] x, input logic [11:0] t);
    logic [7:0] m;
    logic [8:0] r;
    logic [11:0] pn;
    m = mem[a];
    pn = pc_m + 12'h001;
    skip = 1'b0;
    two = 1'b0;
    r = {1'b0, acc_m} + {1'b0, ~m} + {8'h00, cy};
    case (op)
      OP_JUMP: pn = t;
      OP_LOAD_MEM: acc_m = m;
      OP_LOAD_IMM: acc_m = x;
      OP_STORE_ACC: mem[a] = acc_m;
      OP_OR_MEM, OP_OR_IMM: begin
        acc_m = acc_m | (op == OP_OR_IMM ? x : m);
        z = acc_m == 8'h00;
      end
      OP_OR_TO_MEMORY: begin
        mem[a] = acc_m | m;
        z = mem[a] == 8'h00;
      end
      OP_RETURN, OP_RETURN_VALUE, OP_INTERRUPT_RETURN: begin
        pn = stk.pop_back();
        two = 1'b1;
        if (op == OP_RETURN_VALUE) acc_m = x;
        if (op == OP_INTERRUPT_RETURN) gie = 1'b1;
      end
      OP_ROT_LEFT: mem[a] = {m[6:0], m[7]};
      OP_ROT_LEFT_TO_ACC: acc_m = {m[6:0], m[7]};
      OP_ROT_LEFT_CARRY, OP_ROT_LEFT_CARRY_TO_ACC: begin
        if (op == OP_ROT_LEFT_CARRY) mem[a] = {m[6:0], cy};
        else acc_m = {m[6:0], cy};
        cy = m[7];
      end
      OP_ROT_RIGHT: mem[a] = {m[0], m[7:1]};
      OP_ROT_RIGHT_TO_ACC: acc_m = {m[0], m[7:1]};
      OP_ROT_RIGHT_CARRY, OP_ROT_RIGHT_CARRY_TO_ACC: begin
        if (op == OP_ROT_RIGHT_CARRY) mem[a] = {cy, m[7:1]};
        else acc_m = {cy, m[7:1]};
        cy = m[0];
      end
      OP_SUBTRACT_BORROW, OP_SUBTRACT_BORROW_TO_MEM: begin
        // Carry set means no borrow, so the sum form covers both cases
        ac = ({1'b0, acc_m[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cy}) > 5'h0f;
        ov = (acc_m[7] == ~m[7]) && (r[7] != acc_m[7]);
        z = r[7:0] == 8'h00;
        cy = r[8];
        if (op == OP_SUBTRACT_BORROW) acc_m = r[7:0];
        else mem[a] = r[7:0];
      end
      OP_DECREMENT_SKIP_ZERO: begin
        mem[a] = m - 8'h01;
        if (m == 8'h01) begin
          skip = 1'b1;
          two = 1'b1;
          pn = pc_m + 12'h002;
        end
      end
      default: ;
    endcase
    pc_m = pn;
  endtask

  // Push shares its cycle with an interrupt-enable clear so each interrupt return has something to set
  task automatic push(input logic [11:0] v);
    push_valid = 1'b1;
    push_addr = v;
    gie_clear = 1'b1;
    @(posedge clk);
    #1;
    push_valid = 1'b0;
    gie_clear = 1'b0;
    if (stk.size() == 4) stk.delete(0);
    stk.push_back(v);
    gie = 1'b0;
    chk("depth", 12'(stk.size()), {9'h000, stack_depth});
  endtask

  task automatic exec(input mie_op_t op, input logic [2:0] a, input logic [7:0] x, input logic [11:0] t);
    int n;
    if (op inside {OP_RETURN, OP_RETURN_VALUE, OP_INTERRUPT_RETURN}) push(12'(rand16()));
    instr_valid = 1'b1;
    instr_op = op;
    instr_addr = {a, 5'h15};
    peek_addr = {a, 5'h15};
    instr_imm = x;
    instr_target = t;
    n = 0;
    while (instr_ready !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8) begin
      error_cnt++;
      final_report();
    end
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    model(op, a, x, t);
    chk("done", 12'h001, {11'h000, instr_done});
    chk("pc", pc_m, pc);
    chk("acc", {4'h0, acc_m}, {4'h0, accumulator});
    chk("flags", {8'h00, ov, z, ac, cy}, {8'h00, overflow_flag, zero_flag, aux_carry_flag, carry_flag});
    chk("gie", {11'h000, gie}, {11'h000, global_interrupt_enable});
    chk("ready", {11'h000, !two}, {11'h000, instr_ready});
    chk("skip", {11'h000, skip}, {11'h000, skip_taken});
    @(posedge clk);
    #1;
    chk("mem", {4'h0, mem[a]}, {4'h0, peek_data});
    chk("depth", 12'(stk.size()), {9'h000, stack_depth});
  endtask

  initial begin
    int i;
    logic [15:0] r;
    logic [15:0] pairs [4];
    pairs = '{16'h8001, 16'h0000, 16'h7fff, 16'h1001};
    error_cnt = 0;
    checks_done = 0;
    rnd = 16'hc39c;
    {reset_n, instr_valid, push_valid, gie_clear, stack_error_clear} = 5'h00;
    instr_op = OP_NOP;
    {instr_addr, instr_imm, peek_addr} = 24'h000000;
    {instr_target, push_addr} = 24'h000000;
    {acc_m, pc_m, ov, z, ac, cy, gie} = 25'h0000000;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    // Return on the empty stack under a held clear: the set wins, the next cycle clears
    instr_valid = 1'b1;
    instr_op = OP_RETURN;
    stack_error_clear = 1'b1;
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    chk("underflow", 12'h001, {11'h000, stack_underflow});
    @(posedge clk);
    #1;
    stack_error_clear = 1'b0;
    chk("underflow", 12'h000, {11'h000, stack_underflow});
    for (i = 0; i < 8; i++) begin
      exec(OP_LOAD_IMM, i[2:0], 8'(rand16()), 12'h000);
      exec(OP_STORE_ACC, i[2:0], 8'h00, 12'h000);
    end
    for (i = 0; i < 22; i++) exec(mie_op_t'(i), i[2:0], 8'(rand16()), 12'(rand16()));
    // Decrement reaching zero, then wrapping to all ones without a skip
    exec(OP_LOAD_IMM, 3'h0, 8'h01, 12'h000);
    exec(OP_STORE_ACC, 3'h0, 8'h00, 12'h000);
    exec(OP_DECREMENT_SKIP_ZERO, 3'h0, 8'h00, 12'h000);
    exec(OP_DECREMENT_SKIP_ZERO, 3'h0, 8'h00, 12'h000);
    for (i = 0; i < 4; i++) begin
      exec(OP_LOAD_IMM, 3'h1, pairs[i][7:0], 12'h000);
      exec(OP_STORE_ACC, 3'h1, 8'h00, 12'h000);
      exec(OP_LOAD_IMM, 3'h1, pairs[i][15:8], 12'h000);
      exec(OP_SUBTRACT_BORROW, 3'h1, 8'h00, 12'h000);
      exec(OP_SUBTRACT_BORROW_TO_MEM, 3'h1, 8'h00, 12'h000);
    end
    for (i = 0; i < 400; i++) begin
      r = rand16();
      exec(mie_op_t'(5'(r % 16'd22)), r[10:8], 8'(rand16()), 12'(rand16()));
    end
    // Five pushes on four entries: the last overwrites the oldest and is flagged
    for (i = 0; i < 5; i++) begin
      push(12'(rand16()));
      @(posedge clk);
      #1;
    end
    chk("overflow", 12'h001, {11'h000, stack_overflow});
    final_report();
  end
endmodule

bind mie_execute mie_exec_props u_props (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
  .instr_op(instr_op), .instr_imm(instr_imm), .instr_target(instr_target), .push_valid(push_valid),
  .instr_ready(instr_ready), .instr_done(instr_done), .skip_taken(skip_taken), .pc(pc),
  .accumulator(accumulator), .overflow_flag(overflow_flag), .zero_flag(zero_flag),
  .aux_carry_flag(aux_carry_flag), .carry_flag(carry_flag), .global_interrupt_enable(global_interrupt_enable));
`default_nettype wire
